// file: design/eopc_top.v
// exposure timing and serial output port control
// assumes byte register writes on the control port are in the ref_clk domain;
// sync pins and the link clock come from outside and are synchronised here
`timescale 1ns/100ps
`include "eopc_regs.vh"

// How it works
// [RULE1] integrate frame minus (shutter+1) lines
// [RULE2] new shutter takes effect next frame
// [RULE3] frame from sync input or line count
// [RULE4] 18-bit shutter over three bytes, reset zero
// [RULE5] controller keeps shutter in legal range
// [RULE6] slave lines counted from horizontal syncs
// [RULE7] 18-bit line count, reset 465 hex
// [RULE8] longer frame grows trailing blanking
// [RULE9] controller limits exposure near one second
// [RULE10] controller uses 1125 lines in 1080p
// [RULE11] interface pin fixed before reset release
// [RULE12] port select D two, E four channels
// [RULE13] lvds channels mapped to pairs B,C,A,D
// [RULE14] sav words, round-robin pixels, eav words
// [RULE15] serial words sent msb first
// [RULE16] csi lanes 1-4 on pairs A-D
// [RULE17] two or four csi lanes carry data
// [RULE18] pixel format 0a0a raw10, 0c0c raw12
// [RULE19] active lanes 1 two, 3 four
// [RULE20] wired lanes same encoding, reset 3
// [RULE21] unused lanes high impedance when two
// [RULE22] wired extra lanes drive idle signalling; here they also carry the broadcast sav/eav words
// [RULE23] controller writes multibyte values in-frame
module eopc_top #(
    parameter PIX_W      = 12,
    parameter LINE_W     = 18
) (
    input  wire              ref_clk,
    input  wire              rst,
    input  wire              output_interface_pin,
    input  wire              master_mode_pin,
    input  wire              vsync_in,
    input  wire              hsync_in,
    input  wire              link_clk,
    input  wire              reg_wr,
    input  wire              reg_rd,
    input  wire [15:0]       reg_addr,
    input  wire [7:0]        reg_wdata,
    output reg  [7:0]        reg_rdata,
    input  wire              pix_valid,
    input  wire [PIX_W-1:0]  pix_data,
    input  wire              line_start,
    input  wire              line_end,
    output wire              pix_ready,
    output reg               frame_start,
    output reg               shutter_pulse,
    output reg  [LINE_W-1:0] integ_lines,
    output reg  [LINE_W-1:0] frame_lines,
    output wire [3:0]        pair_data,
    output wire [3:0]        pair_oe,
    output wire              csi_clock_out,
    output wire              csi_clock_oe
);
    // ****************************************
    // registers
    // ****************************************
    reg  [LINE_W-1:0] frame_line_count;
    reg  [LINE_W-1:0] shutter_sweep_line;
    reg  [3:0]        output_port_select;
    reg  [1:0]        wired_lane_count;
    reg  [15:0]       csi_pixel_format;
    reg  [1:0]        active_lane_count;
    reg  [LINE_W-1:0] shutter_active;
    reg               is_lvds;
    reg               is_master;
    reg               strap_done;

    always @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            frame_line_count   <= `EOPC_FLC_RESET; // RULE7
            shutter_sweep_line <= `EOPC_SSL_RESET; // RULE4
            output_port_select <= `EOPC_OPS_RESET; // RULE12
            wired_lane_count   <= `EOPC_LANES_RESET; // RULE20
            csi_pixel_format   <= `EOPC_FMT_RESET; // RULE18
            active_lane_count  <= `EOPC_LANES_RESET; // RULE19
        end else if (reg_wr) begin
            case (reg_addr)
                `EOPC_ADDR_FLC_LO:  frame_line_count[7:0]     <= reg_wdata; // RULE7
                `EOPC_ADDR_FLC_MID: frame_line_count[15:8]    <= reg_wdata;
                `EOPC_ADDR_FLC_HI:  frame_line_count[17:16]   <= reg_wdata[1:0];
                `EOPC_ADDR_SSL_LO:  shutter_sweep_line[7:0]   <= reg_wdata; // RULE4
                `EOPC_ADDR_SSL_MID: shutter_sweep_line[15:8]  <= reg_wdata;
                `EOPC_ADDR_SSL_HI:  shutter_sweep_line[17:16] <= reg_wdata[1:0];
                `EOPC_ADDR_OPS:     output_port_select <= reg_wdata[7:4]; // RULE12
                `EOPC_ADDR_WLC:     wired_lane_count   <= reg_wdata[1:0]; // RULE20
                `EOPC_ADDR_FMT_LO:  csi_pixel_format[15:8] <= reg_wdata; // RULE18
                `EOPC_ADDR_FMT_HI:  csi_pixel_format[7:0]  <= reg_wdata;
                `EOPC_ADDR_ALC:     active_lane_count  <= reg_wdata[1:0]; // RULE19
                default: ;
            endcase
        end
    end

    always @* begin
        case (reg_addr)
            `EOPC_ADDR_FLC_LO:  reg_rdata = frame_line_count[7:0];
            `EOPC_ADDR_FLC_MID: reg_rdata = frame_line_count[15:8];
            `EOPC_ADDR_FLC_HI:  reg_rdata = {6'h00, frame_line_count[17:16]};
            `EOPC_ADDR_SSL_LO:  reg_rdata = shutter_sweep_line[7:0];
            `EOPC_ADDR_SSL_MID: reg_rdata = shutter_sweep_line[15:8];
            `EOPC_ADDR_SSL_HI:  reg_rdata = {6'h00, shutter_sweep_line[17:16]};
            `EOPC_ADDR_OPS:     reg_rdata = {output_port_select, 4'h0};
            `EOPC_ADDR_WLC:     reg_rdata = {6'h00, wired_lane_count};
            `EOPC_ADDR_FMT_LO:  reg_rdata = csi_pixel_format[15:8];
            `EOPC_ADDR_FMT_HI:  reg_rdata = csi_pixel_format[7:0];
            `EOPC_ADDR_ALC:     reg_rdata = {6'h00, active_lane_count};
            default:            reg_rdata = 8'h00;
        endcase
    end

    // ****************************************
    // straps, caught after reset release
    // ****************************************
    reg [1:0] strap_s1;
    reg [1:0] strap_s2;
    reg [1:0] strap_s3;
    reg [2:0] strap_fill;
    always @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            strap_s1   <= 2'h0;
            strap_s2   <= 2'h0;
            strap_s3   <= 2'h0;
            strap_fill <= 3'h0;
            strap_done <= 1'b0;
            is_lvds    <= 1'b0;
            is_master  <= 1'b0;
        end else begin
            strap_s1 <= {output_interface_pin, ~master_mode_pin};
            strap_s2 <= strap_s1;
            strap_s3 <= strap_s2;
            // stage contents from reset are not pin levels; wait until flushed
            strap_fill <= {strap_fill[1:0], 1'b1};
            // pins must be settled; sampled once and then ignored
            if (!strap_done && strap_fill[2] && strap_s3 == strap_s2) begin
                strap_done <= 1'b1;
                is_lvds    <= strap_s3[1]; // RULE11
                is_master  <= strap_s3[0];
            end
        end
    end

    // ****************************************
    // sync inputs and link clock synchronisers
    // ****************************************
    reg [2:0] vs_s;
    reg [2:0] hs_s;
    reg [2:0] lk_s;
    always @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            vs_s <= 3'h7;
            hs_s <= 3'h7;
            lk_s <= 3'h0;
        end else begin
            vs_s <= {vs_s[1:0], vsync_in};
            hs_s <= {hs_s[1:0], hsync_in};
            lk_s <= {lk_s[1:0], link_clk};
        end
    end
    // sync inputs are active low; act on falling edges of the second stage
    wire vs_fall = vs_s[2] & ~vs_s[1];
    wire hs_fall = hs_s[2] & ~hs_s[1];
    wire bit_en  = lk_s[1] ^ lk_s[2];

    // ****************************************
    // frame and line timing
    // ****************************************
    reg  [LINE_W-1:0] line_cnt;
    wire              line_tick = is_master ? bit_en & (lk_s[1]) : hs_fall;
    wire              frame_end_m = line_tick && (line_cnt + 18'h00001 >= frame_line_count);
    wire              frame_tick = is_master ? frame_end_m : vs_fall; // RULE3
    always @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            line_cnt       <= {LINE_W{1'b0}};
            frame_lines    <= `EOPC_FLC_RESET;
            shutter_active <= `EOPC_SSL_RESET;
            integ_lines    <= {LINE_W{1'b0}};
            frame_start    <= 1'b0;
            shutter_pulse  <= 1'b0;
        end else begin
            frame_start   <= frame_tick;
            shutter_pulse <= 1'b0;
            if (frame_tick) begin
                // slave counts hsync intervals within one vsync interval
                frame_lines    <= is_master ? frame_line_count : line_cnt; // RULE3 RULE6
                // latch at frame boundary so a change lands in the next frame
                shutter_active <= shutter_sweep_line; // RULE2
                line_cnt       <= {LINE_W{1'b0}};
            end else if (line_tick) begin
                // longer frames simply keep counting, lengthening rear blanking
                line_cnt <= line_cnt + 18'h00001; // RULE8
                if (line_cnt == shutter_active)
                    shutter_pulse <= 1'b1; // RULE1
            end
            integ_lines <= frame_lines - shutter_active - 18'h00001; // RULE1
        end
    end

    // ****************************************
    // output word sequencer
    // ****************************************
    localparam ST_IDLE = 3'b001;
    localparam ST_SAV  = 3'b010;
    localparam ST_PIX  = 3'b100;
    reg  [2:0] state;
    reg  [2:0] sync_cnt;
    reg  [3:0] bit_cnt;
    reg  [1:0] chan;
    reg        eav_pend;
    wire       four_ch   = is_lvds ? (output_port_select == `EOPC_OPS_LVDS4)
                                   : (active_lane_count == `EOPC_LANES_4); // RULE17
    wire [1:0] last_chan = four_ch ? 2'h3 : 2'h1;
    wire [3:0] nbits     = (!is_lvds && csi_pixel_format == `EOPC_FMT_RAW10) ?
                           `EOPC_RAW10_BITS : `EOPC_RAW12_BITS; // RULE18
    wire       word_slot = bit_en && (bit_cnt == 4'h0);
    reg  [PIX_W-1:0] word_out;
    reg  [3:0]       load_ch;
    assign pix_ready = (state == ST_PIX) && word_slot && !eav_pend;

    always @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            state    <= ST_IDLE;
            sync_cnt <= 3'h0;
            bit_cnt  <= 4'h0;
            chan     <= 2'h0;
            eav_pend <= 1'b0;
            word_out <= {PIX_W{1'b0}};
            load_ch  <= 4'h0;
        end else begin
            // staged word waits for the next slot, where the lanes load it
            if (word_slot)
                load_ch <= 4'h0;
            if (bit_en)
                bit_cnt <= (bit_cnt + 4'h1 == nbits) ? 4'h0 : bit_cnt + 4'h1;
            case (state)
                ST_IDLE: begin
                    if (line_start && strap_done) begin
                        state    <= ST_SAV;
                        sync_cnt <= 3'h0;
                        chan     <= 2'h0;
                    end
                end
                ST_SAV: begin
                    if (word_slot) begin
                        // same sync word broadcast to every channel
                        word_out <= eav_pend ? `EOPC_EAV_CODE : `EOPC_SAV_CODE; // RULE14
                        load_ch  <= 4'hf;
                        sync_cnt <= sync_cnt + 3'h1;
                        if (sync_cnt + 3'h1 == `EOPC_SYNC_WORDS) begin
                            state    <= eav_pend ? ST_IDLE : ST_PIX;
                            eav_pend <= 1'b0;
                        end
                    end
                end
                ST_PIX: begin
                    if (word_slot && eav_pend) begin
                        state    <= ST_SAV;
                        sync_cnt <= 3'h0;
                        eav_pend <= 1'b1;
                    end else if (word_slot && pix_valid) begin
                        // one word per slot, channels in order
                        word_out <= pix_data; // RULE14
                        load_ch  <= 4'h1 << chan;
                        chan     <= (chan == last_chan) ? 2'h0 : chan + 2'h1;
                    end
                end
                default: state <= ST_IDLE;
            endcase
            // a close request wins over the clear at the end of a sync run
            if (line_end)
                eav_pend <= 1'b1;
        end
    end

    // ****************************************
    // lane serialisers, channel order 1..4
    // ****************************************
    wire [3:0] ch_bit;
    genvar g;
    generate
        for (g = 0; g < 4; g = g + 1) begin : g_lane
            eopc_lane_ser #(.W(PIX_W)) u_ser (
                .ref_clk (ref_clk),
                .rst     (rst),
                .bit_en  (bit_en),
                .load    (word_slot),
                .word    (load_ch[g] ? word_out : {PIX_W{1'b0}}),
                .nbits   (nbits),
                .sdata   (ch_bit[g])
            );
        end
    endgenerate

    // ****************************************
    // pair mapping: bit 0 = A, 1 = B, 2 = C, 3 = D
    // ****************************************
    // lvds: ch1 B, ch2 C, ch3 A, ch4 D; csi: lane n on pair n
    assign pair_data = is_lvds ? {ch_bit[3], ch_bit[1], ch_bit[0], ch_bit[2]} // RULE13
                               : ch_bit; // RULE16
    wire       wired4  = (wired_lane_count == `EOPC_LANES_4);
    wire       lvds4   = (output_port_select == `EOPC_OPS_LVDS4);
    // extra wired lanes stay driven, low apart from the broadcast sync words, rather than floating
    wire       csi_hi  = four_ch | wired4; // RULE21 RULE22
    wire [3:0] lvds_oe = {lvds4, 1'b1, 1'b1, lvds4}; // RULE13
    wire [3:0] csi_oe  = {csi_hi, csi_hi, 1'b1, 1'b1}; // RULE21 RULE22
    assign pair_oe      = strap_done ? (is_lvds ? lvds_oe : csi_oe) : 4'h0;
    assign csi_clock_out = lk_s[2] & ~is_lvds; // RULE16
    assign csi_clock_oe  = strap_done & ~is_lvds;
endmodule

// file: pkg/eopc_regs.vh
// register map, field layout and timing constants of the exposure / output port block
// included by the top design file only; holds definitions only
`ifndef EOPC_REGS_VH
`define EOPC_REGS_VH

// ****************************************
// register byte addresses
// ****************************************
`define EOPC_ADDR_FLC_LO      16'h3018
`define EOPC_ADDR_FLC_MID     16'h3019
`define EOPC_ADDR_FLC_HI      16'h301a
`define EOPC_ADDR_SSL_LO      16'h3020
`define EOPC_ADDR_SSL_MID     16'h3021
`define EOPC_ADDR_SSL_HI      16'h3022
`define EOPC_ADDR_OPS         16'h3046
`define EOPC_ADDR_WLC         16'h3407
`define EOPC_ADDR_FMT_LO      16'h3441
`define EOPC_ADDR_FMT_HI      16'h3442
`define EOPC_ADDR_ALC         16'h3443

// ****************************************
// reset values and encodings
// ****************************************
`define EOPC_FLC_RESET        18'h00465
`define EOPC_SSL_RESET        18'h00000
`define EOPC_OPS_RESET        4'he
`define EOPC_OPS_LVDS2        4'hd
`define EOPC_OPS_LVDS4        4'he
`define EOPC_OPS_LSB          4
`define EOPC_LANES_RESET      2'h3
`define EOPC_LANES_2          2'h1
`define EOPC_LANES_4          2'h3
`define EOPC_FMT_RESET        16'h0c0c
`define EOPC_FMT_RAW10        16'h0a0a
`define EOPC_FMT_RAW12        16'h0c0c

// ****************************************
// sync words and counts
// ****************************************
`define EOPC_SYNC_WORDS       3'h4
`define EOPC_SAV_CODE         12'h800
`define EOPC_EAV_CODE         12'h9d0
`define EOPC_RAW10_BITS       4'ha
`define EOPC_RAW12_BITS       4'hc

`endif

// file: design/eopc_lane_ser.v
// one serial output lane: loads a word and shifts it out msb first
// assumes a one-cycle bit enable from the parent and words up to 12 bits
`timescale 1ns/100ps
module eopc_lane_ser #(
    parameter W = 12
) (
    input  wire         ref_clk,
    input  wire         rst,
    input  wire         bit_en,
    input  wire         load,
    input  wire [W-1:0] word,
    input  wire [3:0]   nbits,
    output reg          sdata
);
    reg [W-1:0] shreg;

    // ****************************************
    // shifter
    // ****************************************
    always @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            shreg <= {W{1'b0}};
            sdata <= 1'b0;
        end else if (bit_en) begin
            if (load) begin
                // left-justify so 10-bit words also leave msb first
                shreg <= (word << (W - nbits)) << 1; // RULE15
                sdata <= word[nbits-1]; // RULE15
            end else begin
                shreg <= shreg << 1;
                sdata <= shreg[W-1]; // RULE15
            end
        end
    end
endmodule

// file: test/eopc_monitor.sv
// checker for eopc_top: shadows the select and lane fields from port writes
// assumes byte writes land on the ref_clk edge that sees reg_wr
`timescale 1ns/100ps
module eopc_monitor (
    input wire        ref_clk,
    input wire        rst,
    input wire        output_interface_pin,
    input wire        reg_wr,
    input wire [15:0] reg_addr,
    input wire [7:0]  reg_wdata,
    input wire [7:0]  reg_rdata,
    input wire        frame_start,
    input wire [3:0]  pair_oe,
    input wire        csi_clock_oe
);
    reg [3:0] ops_q;
    reg [1:0] alc_q;
    reg [1:0] wlc_q;
    reg [1:0] flc_hi;
    reg [7:0] ssl_lo;
    // ****************************************
    // field shadows
    // ****************************************
    always @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            ops_q  <= 4'he;
            alc_q  <= 2'h3;
            wlc_q  <= 2'h3;
            flc_hi <= 2'h0;
            ssl_lo <= 8'h00;
        end else if (reg_wr) begin
            case (reg_addr)
                16'h3046: ops_q <= reg_wdata[7:4];
                16'h3443: alc_q <= reg_wdata[1:0];
                16'h3407: wlc_q <= reg_wdata[1:0];
                16'h301a: flc_hi <= reg_wdata[1:0];
                16'h3020: ssl_lo <= reg_wdata;
                default: ;
            endcase
        end
    end
    // ****************************************
    // properties
    // ****************************************
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);
    // straps held three edges, the time the design needs to catch them
    sequence lvds_strap;
        output_interface_pin [*3];
    endsequence
    sequence csi_strap;
        !output_interface_pin [*3];
    endsequence
    AST_FRAME_ONE: assert property (frame_start |=> !frame_start)
        else $error("frame start longer than one cycle");
    AST_OPS_READ: assert property (reg_addr == 16'h3046 |-> reg_rdata[7:4] == ops_q)
        else $error("port select readback wrong");
    AST_SSL_READ: assert property (reg_addr == 16'h3020 |-> reg_rdata == ssl_lo)
        else $error("shutter low byte readback wrong");
    AST_FLC_READ: assert property (reg_addr == 16'h301a |-> reg_rdata[1:0] == flc_hi)
        else $error("line count high bits readback wrong");
    AST_LANE_READ: assert property (reg_addr == 16'h3443 |-> reg_rdata[1:0] == alc_q)
        else $error("active lane readback wrong");
    AST_WIRED_READ: assert property (reg_addr == 16'h3407 |-> reg_rdata[1:0] == wlc_q)
        else $error("wired lane readback wrong");
    AST_LVDS2_HIZ: assert property (lvds_strap ##0 (ops_q == 4'hd && $stable(ops_q))
        |-> pair_oe[0] == 1'b0 && pair_oe[3] == 1'b0) else $error("pair a or d driven in two ch");
    AST_LVDS4_ALL: assert property (lvds_strap ##0 (ops_q == 4'he && $stable(ops_q)
        && pair_oe != 4'h0) |-> pair_oe == 4'hf) else $error("four ch pairs not all driven");
    AST_CSI2_HIZ: assert property (csi_strap ##0 (alc_q == 2'h1 && wlc_q == 2'h1)
        |-> pair_oe[3:2] == 2'b00) else $error("lanes three and four driven");
    AST_CSI_EXTRA: assert property (csi_strap ##0 (alc_q == 2'h1 && wlc_q == 2'h3
        && $stable(wlc_q) && pair_oe[0]) |-> pair_oe == 4'hf) else $error("wired lane left idle");
    AST_NO_CSI_CLK: assert property (lvds_strap |-> !csi_clock_oe)
        else $error("csi clock driven in lvds mode");
endmodule

// file: test/eopc_isp_model.sv
// receiver model: makes the link clock and hunts sync words on one pair
// assumes the design moves a bit a few ref_clk cycles after each link edge
`timescale 1ns/100ps
module eopc_isp_model (
    input  wire       run,
    input  wire [1:0] lane_sel,
    input  wire [3:0] pair_data,
    output reg        link_clk,
    output int        sav_hits,
    output int        eav_hits
);
    reg [11:0] sh;
    initial begin
        link_clk = 1'b0;
        sav_hits = 0;
        eav_hits = 0;
        sh = 12'h000;
        #13;
        forever begin
            #40;
            if (run) link_clk = ~link_clk;
        end
    end
    // both edges are bit slots; the last bit is still steady at the edge
    always @(link_clk) begin
        sh = {sh[10:0], pair_data[lane_sel]};
        if (sh == 12'h800) sav_hits++;
        if (sh == 12'h9d0) eav_hits++;
    end
endmodule

// file: test/exposure_and_output_port_control_test.sv
// bench for eopc_top with a receiver model on the output pairs
// drives straps, sync pins, register port and pixels from ref_clk
`timescale 1ns/100ps
module exposure_and_output_port_control_test;
    reg ref_clk = 0, rst = 1, output_interface_pin = 1, master_mode_pin = 0;
    reg vsync_in = 1, hsync_in = 1, reg_wr = 0, reg_rd = 0, pix_valid = 0;
    reg line_start = 0, line_end = 0, link_run = 1;
    reg [15:0] reg_addr = 16'h0000;
    reg [7:0]  reg_wdata = 8'h00;
    reg [11:0] pix_data = 12'h000;
    reg [1:0]  lane_sel = 2'h1;
    wire link_clk, pix_ready, frame_start, shutter_pulse, csi_clock_out, csi_clock_oe;
    wire [7:0] reg_rdata;
    wire [17:0] integ_lines, frame_lines;
    wire [3:0] pair_data, pair_oe;
    int failures = 0, samples_checked = 0, sav_hits, eav_hits, ssl, ssl2, f, h;
    int sp = 0, sp0;
    logic [7:0] rq[$];
    logic [15:0] ra [12] = '{16'h3018, 16'h3019, 16'h301a, 16'h3020, 16'h3021, 16'h3022,
                             16'h3046, 16'h3407, 16'h3441, 16'h3442, 16'h3443, 16'h3000};
    logic [7:0] rv [12] = '{8'h65, 8'h04, 8'h00, 8'h00, 8'h00, 8'h00,
                            8'he0, 8'h03, 8'h0c, 8'h0c, 8'h03, 8'h00};
    eopc_top DUT (.ref_clk(ref_clk), .rst(rst), .output_interface_pin(output_interface_pin),
        .master_mode_pin(master_mode_pin), .vsync_in(vsync_in), .hsync_in(hsync_in),
        .link_clk(link_clk), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .pix_valid(pix_valid),
        .pix_data(pix_data), .line_start(line_start), .line_end(line_end),
        .pix_ready(pix_ready), .frame_start(frame_start), .shutter_pulse(shutter_pulse),
        .integ_lines(integ_lines), .frame_lines(frame_lines), .pair_data(pair_data),
        .pair_oe(pair_oe), .csi_clock_out(csi_clock_out), .csi_clock_oe(csi_clock_oe));
    eopc_isp_model PEER (.run(link_run), .lane_sel(lane_sel), .pair_data(pair_data),
        .link_clk(link_clk), .sav_hits(sav_hits), .eav_hits(eav_hits));
    initial begin
        forever #2 ref_clk = ~ref_clk;
    end
    // ****************************************
    // shared tasks
    // ****************************************
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            failures++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
    endtask
    // all three bytes in one burst so no mixed value is latched
    task automatic wr3(input logic [15:0] a, input logic [17:0] v);
        wr(a, v[7:0]);
        wr(a + 16'h1, v[15:8]);
        wr(a + 16'h2, {6'h00, v[17:16]});
    endtask
    task automatic rd(input logic [15:0] a, input logic [7:0] e);
        @(posedge ref_clk);
        rq.push_back(e);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
    endtask
    always @(posedge ref_clk) begin
        if (reg_rd === 1'b1 && rq.size() > 0) begin
            check(32'(reg_rdata), 32'(rq.pop_front()));
        end
    end
    always @(posedge ref_clk) begin
        if (shutter_pulse === 1'b1) sp++;
    end
    task automatic wait_frame;
        int n;
        n = 0;
        do begin
            @(negedge ref_clk);
            n++;
        end while (frame_start !== 1'b1 && n < 40000);
        if (n >= 40000) failures++;
    endtask
    task automatic do_reset(input logic lvds, input logic slave);
        @(posedge ref_clk);
        rst <= 1'b1;
        output_interface_pin <= lvds;
        master_mode_pin <= slave;
        repeat (12) @(posedge ref_clk);
        rst <= 1'b0;
        repeat (6) @(posedge ref_clk);
    endtask
    task automatic run_line(input logic [3:0] mask, input logic [3:0] oe_exp);
        int k, t, s0, e0;
        logic acc;
        s0 = sav_hits;
        e0 = eav_hits;
        k = 0;
        t = 0;
        @(posedge ref_clk);
        line_start <= 1'b1;
        @(posedge ref_clk);
        line_start <= 1'b0;
        pix_valid <= 1'b1;
        pix_data <= 12'($urandom) & 12'h7ff;
        while (k < 8 && t < 20000) begin
            @(negedge ref_clk);
            acc = (pix_ready === 1'b1);
            t++;
            @(posedge ref_clk);
            if (acc) begin
                k++;
                pix_data <= 12'($urandom) & 12'h7ff;
                if (k == 8) pix_valid <= 1'b0;
            end
        end
        @(negedge ref_clk);
        check(32'(pair_oe & mask), 32'(oe_exp));
        @(posedge ref_clk);
        line_end <= 1'b1;
        @(posedge ref_clk);
        line_end <= 1'b0;
        while (eav_hits < e0 + 4 && t < 40000) begin
            @(posedge ref_clk);
            t++;
        end
        check(32'(sav_hits > s0), 32'd1);
        check(32'(eav_hits > e0), 32'd1);
        $display("line done, oe %h", pair_oe);
    endtask
    // ****************************************
    // main sequence
    // ****************************************
    initial begin
        ssl = $urandom(32'hcd29daec);
        do_reset(1'b1, 1'b0);
        for (f = 0; f < 12; f++) rd(ra[f], rv[f]);
        wr(16'h3000, 8'h5a);
        rd(16'h3000, 8'h00);
        $display("register defaults done");
        ssl = 1 + ($urandom % 5);
        wr3(16'h3018, 18'h00008);
        wr3(16'h3020, 18'(ssl));
        wait_frame;
        sp0 = sp;
        wait_frame;
        check(32'(frame_lines), 32'd8);
        check(32'(sp - sp0), 32'd1);
        check(32'(integ_lines), 32'(7 - ssl));
        ssl2 = 1 + (ssl % 5);
        wr3(16'h3020, 18'(ssl2));
        check(32'(integ_lines), 32'(7 - ssl));
        wait_frame;
        wait_frame;
        check(32'(integ_lines), 32'(7 - ssl2));
        wr3(16'h3018, 18'h0000c);
        wait_frame;
        wait_frame;
        check(32'(integ_lines), 32'(11 - ssl2));
        $display("master timing done");
        wr(16'h3046, 8'hd0);
        rd(16'h3046, 8'hd0);
        run_line(4'b1001, 4'b0000);
        wr(16'h3046, 8'he0);
        run_line(4'b1111, 4'b1111);
        do_reset(1'b1, 1'b1);
        for (f = 0; f < 4; f++) begin
            @(posedge ref_clk) vsync_in <= 1'b0;
            repeat (4) @(posedge ref_clk);
            vsync_in <= 1'b1;
            for (h = 0; h < 6 && f < 3; h++) begin
                repeat (20) @(posedge ref_clk);
                hsync_in <= 1'b0;
                repeat (4) @(posedge ref_clk);
                hsync_in <= 1'b1;
            end
        end
        repeat (10) @(posedge ref_clk);
        check(32'(frame_lines), 32'd6);
        $display("slave timing done");
        do_reset(1'b0, 1'b0);
        lane_sel = 2'h0;
        wr(16'h3443, 8'h01);
        wr(16'h3407, 8'h01);
        run_line(4'b1100, 4'b0000);
        wr(16'h3407, 8'h03);
        run_line(4'b1100, 4'b1100);
        wr(16'h3443, 8'h03);
        run_line(4'b1111, 4'b1111);
        check(32'(csi_clock_oe), 32'd1);
        wr(16'h3441, 8'h0a);
        wr(16'h3442, 8'h0a);
        rd(16'h3441, 8'h0a);
        rd(16'h3442, 8'h0a);
        $display("csi lanes done");
        report_and_stop;
    end
    initial begin
        #200000;
        failures++;
        report_and_stop;
    end
endmodule
bind eopc_top eopc_monitor MON (.ref_clk(ref_clk), .rst(rst),
    .output_interface_pin(output_interface_pin), .reg_wr(reg_wr), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .frame_start(frame_start),
    .pair_oe(pair_oe), .csi_clock_oe(csi_clock_oe));
